// ===== lbsm_frame_timer.sv
// Frame timer: divides the core clock into backplane phases and half frames.
// Assumes phase_count holds 1, 2 or 4 and may change at any time.
`timescale 1ns/1ps
module lbsm_frame_timer import lbsm_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [2:0] phase_count,
   output logic [1:0] phase_ff,
   output logic pol_ff,
   output logic step_ff,
   output logic frame_start_ff
);
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic [1:0] nxt_phase;
   logic nxt_pol;
   logic nxt_step;
   logic nxt_frame_start;

   always_comb begin
      nxt_cnt = cnt_ff + 16'h0001;
      nxt_phase = phase_ff;
      nxt_pol = pol_ff;
      nxt_step = 1'b0;
      nxt_frame_start = 1'b0;
      if (cnt_ff == PHASE_CYCLES - 16'h0001) begin
         nxt_cnt = 16'h0000;
         nxt_step = 1'b1;
         if ({1'b0, phase_ff} >= phase_count - 3'h1) begin
            nxt_phase = 2'h0;
            nxt_pol = ~pol_ff;
            nxt_frame_start = pol_ff;
         end else begin
            nxt_phase = phase_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 16'h0000;
         phase_ff <= 2'h0;
         pol_ff <= 1'b0;
         step_ff <= 1'b0;
         frame_start_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         phase_ff <= nxt_phase;
         pol_ff <= nxt_pol;
         step_ff <= nxt_step;
         frame_start_ff <= nxt_frame_start;
      end
   end
endmodule : lbsm_frame_timer

// ===== lbsm_glass.sv
// Passive glass model: sums backplane minus segment level over all elements.
// Assumes level indices from the sequencer; the window is given in cycles.
`timescale 1ns/1ps
module lbsm_glass import lbsm_pkg::*; (
   input wire logic core_clk,
   input wire logic clr,
   input wire logic [31:0] win_len,
   input wire logic [NUM_BP*LVL_W-1:0] bp_lvl,
   input wire logic [NUM_SEG*LVL_W-1:0] seg_lvl,
   output logic [31:0] net_sum
);
   int cnt;
   int d;
   // The glass only tolerates zero net voltage over one whole frame.
   always @(posedge core_clk) begin
      d = 0;
      for (int b = 0; b < NUM_BP; b++) begin
         for (int s = 0; s < NUM_SEG; s++) begin
            d += int'(bp_lvl[b*LVL_W +: LVL_W]);
            d -= int'(seg_lvl[s*LVL_W +: LVL_W]);
         end
      end
      if (clr) begin
         cnt <= 0;
         net_sum <= '0;
      end else if (cnt < int'(win_len)) begin
         cnt <= cnt + 1;
         net_sum <= net_sum + 32'(d);
      end
   end
endmodule : lbsm_glass

// ===== lbsm_pkg.sv
// Constants shared by the segment multiplex sequencer and its frame timer.
// Assumes a single 200 MHz core clock and a plain register port.
package lbsm_pkg;
   localparam int NUM_SEG = 44;
   localparam int NUM_ROW = 8;
   localparam int NUM_BP = 4;
   localparam int BANK_ROWS = 4;
   localparam int LVL_W = 3;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PTR_W = 6;
   localparam int BYTE_BITS = 8;
   // Register offsets.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_PTR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   // Control and status register fields.
   localparam int CTRL_MUX_LSB = 0;
   localparam int CTRL_BIAS_LSB = 2;
   localparam int CTRL_IBS_BIT = 4;
   localparam int CTRL_OBS_BIT = 5;
   localparam int CTRL_EN_BIT = 6;
   localparam int STAT_POL_BIT = 2;
   // Multiplex mode codes.
   localparam logic [1:0] MUX_STATIC = 2'h0;
   localparam logic [1:0] MUX_1TO2 = 2'h1;
   localparam logic [1:0] MUX_1TO4 = 2'h2;
   // Bias term a: fraction is 1/(1+a).
   localparam logic [1:0] BIAS_HALF = 2'h1;
   localparam logic [1:0] BIAS_THIRD = 2'h2;
   localparam logic [1:0] BIAS_QUARTER = 2'h3;
   localparam logic [1:0] CTRL_MUX_RST = 2'h2;
   localparam logic [1:0] CTRL_BIAS_RST = 2'h2;
   // Phases per frame half for each mode.
   localparam logic [2:0] PHASES_STATIC = 3'h1;
   localparam logic [2:0] PHASES_1TO2 = 3'h2;
   localparam logic [2:0] PHASES_1TO4 = 3'h4;
   // Pointer step per data byte for each mode.
   localparam logic [PTR_W-1:0] STEP_STATIC = 6'h08;
   localparam logic [PTR_W-1:0] STEP_1TO2 = 6'h04;
   localparam logic [PTR_W-1:0] STEP_1TO4 = 6'h02;
   localparam logic [PTR_W-1:0] PTR_END = 6'h2C;
   // Bias level indices.
   localparam logic [LVL_W-1:0] LVL_ZERO = 3'h0;
   localparam logic [LVL_W-1:0] LVL_ONE = 3'h1;
   localparam logic [LVL_W-1:0] LVL_TWO = 3'h2;
   // Core clock cycles per backplane phase.
   localparam logic [15:0] PHASE_CYCLES = 16'h03E8;
endpackage : lbsm_pkg

// ===== lbsm_seg_mux.sv
// Segment LCD multiplex sequencer: display RAM, display register and
// bias level selection for four backplanes and 44 segments.
// Assumes a register master on core_clk; outputs are bias level indices.
`timescale 1ns/1ps
module lbsm_seg_mux import lbsm_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata_ff,
   output logic [LVL_W-1:0] backplane_out_first,
   output logic [LVL_W-1:0] backplane_out_second,
   output logic [LVL_W-1:0] backplane_out_third,
   output logic [LVL_W-1:0] backplane_out_fourth,
   output logic [NUM_SEG*LVL_W-1:0] segment_outputs
);
   function automatic logic [LVL_W-1:0] mirror(input logic [LVL_W-1:0] lv,
      input logic pol, input logic [LVL_W-1:0] full);
      mirror = pol ? full - lv : lv;
   endfunction : mirror

   function automatic logic [2:0] phases_of(input logic [1:0] mux);
      unique case (mux)
         MUX_STATIC: phases_of = PHASES_STATIC;
         MUX_1TO2: phases_of = PHASES_1TO2;
         default: phases_of = PHASES_1TO4;
      endcase
   endfunction : phases_of

   logic [1:0] mux_ff, nxt_mux;
   logic [1:0] bias_ff, nxt_bias;
   logic ibs_ff, nxt_ibs;
   logic output_bank_select_ff, nxt_output_bank_select;
   logic en_ff, nxt_en;
   logic [PTR_W-1:0] ptr_ff, nxt_ptr;
   logic [NUM_SEG-1:0] ram_ff [NUM_ROW];
   logic [NUM_SEG-1:0] nxt_ram [NUM_ROW];
   logic [NUM_SEG-1:0] disp_ff [BANK_ROWS];
   logic [NUM_SEG-1:0] nxt_disp [BANK_ROWS];
   logic [DATA_W-1:0] nxt_rdata;
   logic [LVL_W-1:0] bp_ff [NUM_BP];
   logic [LVL_W-1:0] nxt_bp [NUM_BP];
   logic [NUM_SEG*LVL_W-1:0] seg_ff, nxt_seg;
   logic [1:0] phase_i;
   logic pol_i;
   logic step_i;
   logic frame_start_i;
   logic [LVL_W-1:0] full_lvl;
   logic [PTR_W-1:0] step_sz;

   lbsm_frame_timer u_timer (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .phase_count(phases_of(mux_ff)),
      .phase_ff(phase_i),
      .pol_ff(pol_i),
      .step_ff(step_i),
      .frame_start_ff(frame_start_i)
   );

   // Register file, pointer and display RAM.
   always_comb begin
      int col;
      int row;
      nxt_mux = mux_ff;
      nxt_bias = bias_ff;
      nxt_ibs = ibs_ff;
      nxt_output_bank_select = output_bank_select_ff;
      nxt_en = en_ff;
      nxt_ptr = ptr_ff;
      nxt_ram = ram_ff;
      nxt_rdata = '0;
      col = 0;
      row = 0;
      unique case (mux_ff)
         MUX_STATIC: step_sz = STEP_STATIC;
         MUX_1TO2: step_sz = STEP_1TO2;
         default: step_sz = STEP_1TO4;
      endcase
      if (reg_wr) begin
         if (reg_addr == REG_CTRL) begin
            if (reg_wdata[CTRL_MUX_LSB+:2] != 2'h3) begin
               nxt_mux = reg_wdata[CTRL_MUX_LSB+:2];
            end
            if (reg_wdata[CTRL_BIAS_LSB+:2] != 2'h0) begin
               nxt_bias = reg_wdata[CTRL_BIAS_LSB+:2];
            end
            nxt_ibs = reg_wdata[CTRL_IBS_BIT];
            nxt_output_bank_select = reg_wdata[CTRL_OBS_BIT];
            nxt_en = reg_wdata[CTRL_EN_BIT];
         end else if (reg_addr == REG_PTR) begin
            nxt_ptr = (reg_wdata[PTR_W-1:0] > PTR_END) ? PTR_END
                      : reg_wdata[PTR_W-1:0];
         end else if (reg_addr == REG_DATA && ptr_ff < PTR_END) begin
            for (int j = 0; j < BYTE_BITS; j++) begin
               unique case (mux_ff)
                  MUX_STATIC: begin
                     col = int'(ptr_ff) + j;
                     row = 0;
                  end
                  MUX_1TO2: begin
                     col = int'(ptr_ff) + j / 2;
                     row = j % 2;
                  end
                  default: begin
                     col = int'(ptr_ff) + j / 4;
                     row = j % 4;
                  end
               endcase
               if (ibs_ff) begin
                  row = row + BANK_ROWS;
               end
               if (col < NUM_SEG) begin
                  nxt_ram[row][col] = reg_wdata[BYTE_BITS-1-j];
               end
            end
            nxt_ptr = (ptr_ff + step_sz >= PTR_END) ? PTR_END
                      : ptr_ff + step_sz;
         end
      end
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: begin
               nxt_rdata[CTRL_MUX_LSB+:2] = mux_ff;
               nxt_rdata[CTRL_BIAS_LSB+:2] = bias_ff;
               nxt_rdata[CTRL_IBS_BIT] = ibs_ff;
               nxt_rdata[CTRL_OBS_BIT] = output_bank_select_ff;
               nxt_rdata[CTRL_EN_BIT] = en_ff;
            end
            REG_PTR: nxt_rdata[PTR_W-1:0] = ptr_ff;
            REG_STAT: begin
               nxt_rdata[1:0] = phase_i;
               nxt_rdata[STAT_POL_BIT] = pol_i;
            end
            default: nxt_rdata = '0;
         endcase
      end
   end

   // Display register and level selection.
   always_comb begin
      logic [1:0] sig;
      logic on;
      sig = 2'h0;
      on = 1'b0;
      nxt_disp = disp_ff;
      if (frame_start_i) begin
         for (int r = 0; r < BANK_ROWS; r++) begin
            nxt_disp[r] = ram_ff[output_bank_select_ff ? r + BANK_ROWS : r];
         end
      end
      full_lvl = (mux_ff == MUX_STATIC) ? LVL_ONE
                 : {1'b0, bias_ff} + LVL_ONE;
      for (int b = 0; b < NUM_BP; b++) begin
         unique case (mux_ff)
            MUX_STATIC: sig = 2'h0;
            MUX_1TO2: sig = 2'(b % 2);
            default: sig = 2'(b);
         endcase
         if (!en_ff) begin
            nxt_bp[b] = LVL_ZERO;
         end else if (sig == phase_i) begin
            nxt_bp[b] = mirror(full_lvl, pol_i, full_lvl);
         end else begin
            nxt_bp[b] = mirror(LVL_ONE, pol_i, full_lvl);
         end
      end
      for (int s = 0; s < NUM_SEG; s++) begin
         on = disp_ff[phase_i][s];
         if (!en_ff) begin
            nxt_seg[s*LVL_W+:LVL_W] = LVL_ZERO;
         end else if (mux_ff == MUX_STATIC) begin
            nxt_seg[s*LVL_W+:LVL_W] = mirror(on ? LVL_ZERO : full_lvl,
                                             pol_i, full_lvl);
         end else begin
            // a set bit drives opposite to the selected backplane.
            nxt_seg[s*LVL_W+:LVL_W] = mirror(on ? LVL_ZERO : LVL_TWO,
                                             pol_i, full_lvl);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mux_ff <= CTRL_MUX_RST;
         bias_ff <= CTRL_BIAS_RST;
         ibs_ff <= 1'b0;
         output_bank_select_ff <= 1'b0;
         en_ff <= 1'b0;
         ptr_ff <= '0;
         reg_rdata_ff <= '0;
         seg_ff <= '0;
         for (int r = 0; r < NUM_ROW; r++) begin
            ram_ff[r] <= '0;
         end
         for (int r = 0; r < BANK_ROWS; r++) begin
            disp_ff[r] <= '0;
         end
         for (int b = 0; b < NUM_BP; b++) begin
            bp_ff[b] <= LVL_ZERO;
         end
      end else begin
         mux_ff <= nxt_mux;
         bias_ff <= nxt_bias;
         ibs_ff <= nxt_ibs;
         output_bank_select_ff <= nxt_output_bank_select;
         en_ff <= nxt_en;
         ptr_ff <= nxt_ptr;
         reg_rdata_ff <= nxt_rdata;
         seg_ff <= nxt_seg;
         ram_ff <= nxt_ram;
         disp_ff <= nxt_disp;
         bp_ff <= nxt_bp;
      end
   end

   assign backplane_out_first = bp_ff[0];
   assign backplane_out_second = bp_ff[1];
   assign backplane_out_third = bp_ff[2];
   assign backplane_out_fourth = bp_ff[3];
   assign segment_outputs = seg_ff;

   a_static_bp_same: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $past(mux_ff) == MUX_STATIC |-> backplane_out_second ==
      backplane_out_first && backplane_out_fourth == backplane_out_first)
      else $error("static backplanes differ");
   a_half_bp_copy: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $past(mux_ff) == MUX_1TO2 |-> backplane_out_third ==
      backplane_out_first && backplane_out_fourth == backplane_out_second)
      else $error("1:2 backplane copies wrong");
   a_quad_bp_distinct: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $past(mux_ff) == MUX_1TO4 && $past(en_ff) |->
      (backplane_out_first != backplane_out_second) ==
      ($past(phase_i) < 2'h2))
      else $error("1:4 backplanes not distinct");
   a_static_two_lvls: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $past(mux_ff) == MUX_STATIC |->
      backplane_out_first == LVL_ZERO || backplane_out_first == LVL_ONE)
      else $error("static uses extra level");
   a_bias_full_lvl: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $past(mux_ff) == MUX_1TO4 && $past(en_ff) && !$past(pol_i) &&
      $past(phase_i) == 2'h0 |->
      backplane_out_first == {1'b0, $past(bias_ff)} + LVL_ONE)
      else $error("selected level not 1+a");
   a_pol_toggle: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      step_i && phase_i == 2'h0 |-> pol_i != $past(pol_i))
      else $error("polarity did not alternate");
   a_disp_stable: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !frame_start_i |=> disp_ff[0] == $past(disp_ff[0]))
      else $error("display register changed mid frame");
   a_ptr_step: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      reg_wr && reg_addr == REG_DATA && ptr_ff + step_sz < PTR_END |=>
      ptr_ff == $past(ptr_ff) + $past(step_sz))
      else $error("pointer step wrong");
   a_seg_on_lvl: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      en_ff && !pol_i && disp_ff[phase_i][0] |=>
      segment_outputs[LVL_W-1:0] == LVL_ZERO)
      else $error("on segment not at zero level");
endmodule : lbsm_seg_mux

// ===== tb_lbsm_seg_mux.sv
// Self-checking bench for the segment multiplex sequencer and glass model.
// Assumes one 200 MHz clock and the register map of the package.
`timescale 1ns/1ps
module tb_lbsm_seg_mux import lbsm_pkg::*;;
   logic core_clk, rst_b, reg_wr, reg_rd, clr;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata_ff, rd_val;
   logic [NUM_BP-1:0][LVL_W-1:0] bp;
   logic [NUM_SEG*LVL_W-1:0] seg;
   logic [31:0] net_sum, win_len;
   int errors, num_checks, seed, mux, bias, ibs, output_bank_select, ptr;
   int ram [NUM_ROW][NUM_SEG];

   lbsm_seg_mux i_lbsm_seg_mux (.core_clk(core_clk), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .backplane_out_first(bp[0]), .backplane_out_second(bp[1]),
      .backplane_out_third(bp[2]), .backplane_out_fourth(bp[3]),
      .segment_outputs(seg));
   lbsm_glass i_lbsm_glass (.core_clk(core_clk), .clr(clr),
      .win_len(win_len), .bp_lvl({bp[3], bp[2], bp[1], bp[0]}),
      .seg_lvl(seg), .net_sum(net_sum));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task results;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results

   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task chk_lvl(input logic [LVL_W-1:0] got, input logic [LVL_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_lvl

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata_ff;
   endtask : rd

   // Model of the filling order: bit 7 first, rows per column by mode.
   task put_byte(input logic [7:0] b);
      int st;
      int nr;
      st = (mux == 0) ? 8 : ((mux == 1) ? 4 : 2);
      nr = 8 / st;
      for (int k = 0; k < st; k++) begin
         for (int r = 0; r < nr; r++) begin
            if (ptr + k < NUM_SEG) begin
               ram[r + 4 * ibs][ptr + k] = b[7 - k * nr - r];
            end
         end
      end
      ptr = (ptr + st > NUM_SEG) ? NUM_SEG : ptr + st;
      wr(REG_DATA, {24'h0, b});
   endtask : put_byte

   function int lvl(input int is_bp, input int i, input int ph, input int pol);
      int full;
      int k;
      int j;
      full = (mux == 0) ? 1 : 1 + bias;
      j = (mux == 1) ? i % 2 : ((mux == 2) ? i : 0);
      if (is_bp != 0) k = (mux == 0) ? 1 : ((ph == j) ? 1 + bias : 1);
      else k = (ram[ph + 4 * output_bank_select][i] != 0) ? 0 : ((mux == 0) ? 1 : 2);
      return (pol != 0) ? full - k : k;
   endfunction : lvl

   task chk_out(input int ph, input int pol);
      for (int i = 0; i < NUM_BP; i++) begin
         chk_lvl(bp[i], 3'(lvl(1, i, ph, pol))); // mapping
      end
      for (int s = 0; s < NUM_SEG; s++) begin
         chk_lvl(seg[s*LVL_W +: LVL_W], 3'(lvl(0, s, ph, pol)));
      end
   endtask : chk_out

   task run_cfg(input int m, input int b, input int ib, input int ob);
      int n;
      int nb;
      int t;
      logic [31:0] cv;
      mux = m;
      bias = b;
      ibs = ib;
      output_bank_select = ob;
      n = (m == 0) ? 1 : ((m == 1) ? 2 : 4);
      cv = 32'(m + 4 * b + 16 * ib + 32 * ob + 64);
      wr(REG_CTRL, cv);
      rd(REG_CTRL);
      chk_reg(rd_val, cv); // settings kept
      wr(REG_PTR, 32'h0);
      ptr = 0;
      nb = (NUM_SEG + 8 / n - 1) / (8 / n) + 1;
      repeat (nb) put_byte(8'($random(seed)));
      rd(REG_PTR);
      chk_reg(rd_val, 32'h2C); // pointer stops
      t = 0;
      do begin
         rd(REG_STAT);
         t++;
      end while (rd_val[2] !== 1'b1 && t < 9000);
      chk_reg(32'(rd_val[2]), 32'h1); // odd half seen
      do begin
         rd(REG_STAT);
         t++;
      end while (rd_val[2] !== 1'b0 && t < 18000);
      chk_reg(32'(rd_val[2]), 32'h0); // frame start seen
      win_len <= 32'(2000 * n);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      for (int p = 0; p < 2 * n; p++) begin
         repeat (497) @(posedge core_clk);
         rd(REG_STAT);
         chk_reg(32'(rd_val[2:0]), 32'((p / n) * 4 + p % n));
         chk_out(int'(rd_val[1:0]), int'(rd_val[2]));
         repeat (500) @(posedge core_clk);
      end
      // The glass window closes 2000n cycles after the clear edge.
      repeat (2 * n + 4) @(posedge core_clk);
      chk_reg(net_sum, 32'h0); // zero average
      $display("test done mux %0d bias %0d", m, b);
   endtask : run_cfg

   initial begin
      repeat (80000) @(posedge core_clk);
      errors++;
      results();
   end

   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      clr = 1'b0;
      win_len = '0;
      seed = 32'h2AC8;
      errors = 0;
      num_checks = 0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      #1;
      for (int i = 0; i < NUM_BP; i++) chk_lvl(bp[i], 3'h0); // idle low
      for (int s = 0; s < NUM_SEG; s++) begin
         chk_lvl(seg[s*LVL_W +: LVL_W], 3'h0); // idle low
      end
      rd(REG_CTRL);
      chk_reg(rd_val, 32'h0A); // reset settings
      @(posedge core_clk);
      #1;
      chk_reg(reg_rdata_ff, 32'h0); // read data one cycle
      rd(8'h10);
      chk_reg(rd_val, 32'h0); // unmapped read
      wr(REG_CTRL, 32'h03);
      rd(REG_CTRL);
      chk_reg(rd_val, 32'h0A); // bad codes refused
      wr(REG_PTR, 32'h3F);
      rd(REG_PTR);
      chk_reg(rd_val, 32'h2C); // pointer limit
      $display("test done reset");
      run_cfg(0, 1, 0, 0); // static
      run_cfg(1, 1, 1, 0); // half bias
      run_cfg(1, 2, 0, 1); // third bias
      run_cfg(2, 3, 1, 1); // quarter bias
      results();
   end
endmodule : tb_lbsm_seg_mux
